// file: core/apmrb_top.sv
`timescale 1ns/100ps
`include "apmrb_params.svh"
module apmrb_top
  import apmrb_pkg::*;
#(
  parameter int unsigned BAND1_CYC = `APMRB_BAND1_CYC,
  parameter int unsigned BAND2_CYC = `APMRB_BAND2_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Add-on slot types, from slot detect pins
  input wire apmrb_type_t slot_type_pin [`APMRB_SLOTS],
  // Reset button, high while pressed
  input wire logic btn_pin,
  // Program control requests, one bit per program
  input wire logic [`APMRB_PROGS-1:0] host_program_start_call,
  input wire logic [`APMRB_PROGS-1:0] host_program_stop_call,
  input wire logic [`APMRB_PROGS-1:0] prog_start_req,
  input wire logic [`APMRB_PROGS-1:0] prog_stop_req,
  // Pin numbering
  output apmrb_slot_map_t slot_map [`APMRB_SLOTS],
  output logic [7:0] pin_total,
  output logic renumber_pulse,
  output logic outputs_clear,
  // Indicators and resets
  output logic led_ch1_red,
  output logic led_ch2_red,
  output apmrb_reset_t reset_pulse,
  // Program events
  output logic [`APMRB_PROGS-1:0] prog_running,
  output logic [`APMRB_PROGS-1:0] start_event,
  output logic [`APMRB_PROGS-1:0] stop_event
);
  // Three-stage synchronisers; the first stage feeds only the second
  apmrb_type_t ty_s1_ff [`APMRB_SLOTS];
  apmrb_type_t ty_s2_ff [`APMRB_SLOTS];
  apmrb_type_t ty_s3_ff [`APMRB_SLOTS];
  apmrb_type_t ty_ok_ff [`APMRB_SLOTS];
  apmrb_type_t nxt_ty_ok [`APMRB_SLOTS];
  logic [2:0] btn_sync_ff;
  logic btn_ff;
  logic [`APMRB_SLOTS-1:0] ty_diff;
  genvar gi;
  generate
    for (gi = 0; gi < `APMRB_SLOTS; gi++) begin : g_sync
      assign nxt_ty_ok[gi] = (ty_s2_ff[gi] == ty_s3_ff[gi]) ? ty_s3_ff[gi] : ty_ok_ff[gi];
      assign ty_diff[gi] = (nxt_ty_ok[gi] != ty_ok_ff[gi]);
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          ty_s1_ff[gi] <= `APMRB_TYPE_NONE;
          ty_s2_ff[gi] <= `APMRB_TYPE_NONE;
          ty_s3_ff[gi] <= `APMRB_TYPE_NONE;
          ty_ok_ff[gi] <= `APMRB_TYPE_NONE;
        end else begin
          ty_s1_ff[gi] <= slot_type_pin[gi];
          ty_s2_ff[gi] <= ty_s1_ff[gi];
          ty_s3_ff[gi] <= ty_s2_ff[gi];
          ty_ok_ff[gi] <= nxt_ty_ok[gi];
        end
      end
    end
  endgenerate

  // Numbering is combinational on the settled types and registered below
  // The registered map lands one cycle after the renumber pulse
  apmrb_slot_map_t map_c [`APMRB_SLOTS];
  logic [7:0] total_c;
  apmrb_slot_numberer u_numberer (
    .slot_type(ty_ok_ff),
    .slot_map(map_c),
    .pin_total(total_c)
  );
  wire lineup_change = |ty_diff;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      renumber_pulse <= 1'b0;
      outputs_clear <= 1'b0;
      pin_total <= 8'h00;
      for (int i = 0; i < `APMRB_SLOTS; i++) slot_map[i] <= '0;
    end else begin
      renumber_pulse <= lineup_change;
      outputs_clear <= lineup_change;
      pin_total <= total_c;
      for (int i = 0; i < `APMRB_SLOTS; i++) slot_map[i] <= map_c[i];
    end
  end

  // Button hold timer
  wire btn_nxt = (btn_sync_ff[1] == btn_sync_ff[2]) ? btn_sync_ff[2] : btn_ff;
  apmrb_btn_state_t st_ff;
  apmrb_btn_state_t nxt_st;
  logic [31:0] hold_ff;
  wire pressed = btn_nxt;
  wire released = btn_ff & ~btn_nxt;
  wire [31:0] nxt_hold = pressed ? (hold_ff + 32'h00000001) : 32'h00000000;
  // Past the second band nothing else is documented; the two-LED band is kept
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      APMRB_IDLE: if (pressed) nxt_st = APMRB_BAND1;
      APMRB_BAND1: begin
        if (!pressed) nxt_st = APMRB_IDLE;
        else if (hold_ff >= BAND1_CYC - 1) nxt_st = APMRB_BAND2;
      end
      APMRB_BAND2: if (!pressed) nxt_st = APMRB_IDLE;
      default: nxt_st = APMRB_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      btn_sync_ff <= 3'h0;
      btn_ff <= 1'b0;
      hold_ff <= 32'h00000000;
      st_ff <= APMRB_IDLE;
      led_ch1_red <= 1'b0;
      led_ch2_red <= 1'b0;
      reset_pulse <= '0;
    end else begin
      btn_sync_ff <= {btn_sync_ff[1:0], btn_pin};
      btn_ff <= btn_nxt;
      hold_ff <= nxt_hold;
      st_ff <= nxt_st;
      led_ch1_red <= (nxt_st != APMRB_IDLE);
      led_ch2_red <= (nxt_st == APMRB_BAND2);
      reset_pulse.all_modules <= released;
      reset_pulse.net_factory <= released & (st_ff == APMRB_BAND2);
    end
  end

  // Program events; stop only fires for a running program
  wire [`APMRB_PROGS-1:0] start_any = host_program_start_call | prog_start_req;
  wire [`APMRB_PROGS-1:0] stop_any = (host_program_stop_call | prog_stop_req) & prog_running;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prog_running <= '0;
      start_event <= '0;
      stop_event <= '0;
    end else begin
      start_event <= start_any;
      stop_event <= stop_any;
      // Start wins over a simultaneous stop so a new program is not lost
      prog_running <= (prog_running & ~stop_any) | start_any;
    end
  end

  // Cycles spent in the first band; lets a check bound the band length
  logic [31:0] band1_cnt_ff;
  wire [31:0] nxt_band1_cnt = (st_ff == APMRB_BAND1 && btn_nxt) ? (band1_cnt_ff + 32'h00000001) : 32'h00000000;
  always_ff @(posedge clk_sys) begin
    if (reset) band1_cnt_ff <= 32'h00000000;
    else band1_cnt_ff <= nxt_band1_cnt;
  end

  // Button and indicator checks
  AST_LED_AT_PRESS: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(btn_ff) |-> led_ch1_red) else $error("first led not lit on press");
  AST_BAND1_ONE_LED: assert property (@(posedge clk_sys) disable iff (reset)
    (st_ff == APMRB_BAND1) |-> !led_ch2_red || $past(st_ff) == APMRB_BAND2)
    else $error("second led lit in first band");
  AST_BAND2_TWO_LED: assert property (@(posedge clk_sys) disable iff (reset)
    (st_ff == APMRB_BAND2 && btn_nxt) |=> led_ch1_red && led_ch2_red)
    else $error("second band leds wrong");
  AST_LED2_WITH_LED1: assert property (@(posedge clk_sys) disable iff (reset)
    led_ch2_red |-> led_ch1_red) else $error("second led lit without first");
  AST_BAND_BOUND: assert property (@(posedge clk_sys) disable iff (reset)
    band1_cnt_ff <= BAND1_CYC) else $error("first band held too long");
  AST_RELEASE_ALL: assert property (@(posedge clk_sys) disable iff (reset)
    released |=> reset_pulse.all_modules) else $error("no module reset on release");
  AST_RELEASE_TYPE: assert property (@(posedge clk_sys) disable iff (reset)
    released |=> reset_pulse.net_factory == ($past(st_ff) == APMRB_BAND2))
    else $error("reset type not matched to band");
  AST_FACTORY_WITH_ALL: assert property (@(posedge clk_sys) disable iff (reset)
    reset_pulse.net_factory |-> reset_pulse.all_modules) else $error("factory reset without module reset");
  AST_RESET_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (reset)
    reset_pulse.all_modules |=> !reset_pulse.all_modules) else $error("module reset longer than one cycle");
  AST_NO_RESET_HELD: assert property (@(posedge clk_sys) disable iff (reset)
    btn_ff |-> !reset_pulse.all_modules) else $error("reset issued while button held");
  AST_LEDS_OFF_RELEASED: assert property (@(posedge clk_sys) disable iff (reset)
    reset_pulse.all_modules |-> !led_ch1_red && !led_ch2_red) else $error("leds still lit after release");

  // Numbering checks; a new map may only appear right after a renumber pulse
  AST_RENUMBER_CLEAR: assert property (@(posedge clk_sys) disable iff (reset)
    lineup_change |=> outputs_clear && renumber_pulse ##1 pin_total == $past(total_c))
    else $error("renumber did not clear outputs");
  AST_CLEAR_WITH_RENUMBER: assert property (@(posedge clk_sys) disable iff (reset)
    outputs_clear == renumber_pulse) else $error("output clear not paired with renumber");
  AST_MAP_HELD: assert property (@(posedge clk_sys) disable iff (reset)
    !$past(renumber_pulse) |-> $stable(pin_total))
    else $error("pin total moved without a renumber");
  AST_FIRST_BASE: assert property (@(posedge clk_sys) disable iff (reset)
    slot_map[0].base == 8'h00) else $error("first slot base not zero");
  generate
    for (gi = 0; gi < `APMRB_SLOTS; gi++) begin : g_count_chk
      AST_SLOT_COUNT: assert property (@(posedge clk_sys) disable iff (reset)
        slot_map[gi].count == `APMRB_PINS_NONE || slot_map[gi].count == `APMRB_PINS_ANALOG ||
        slot_map[gi].count == `APMRB_PINS_DIGITAL) else $error("slot pin count not a module size");
    end
  endgenerate
  generate
    for (gi = 1; gi < `APMRB_SLOTS; gi++) begin : g_chain_chk
      AST_BASE_CHAIN: assert property (@(posedge clk_sys) disable iff (reset)
        slot_map[gi].base == slot_map[gi-1].base + {1'b0, slot_map[gi-1].count})
        else $error("slot base not the sum of the slots to its left");
    end
  endgenerate
  AST_TOTAL_LAST: assert property (@(posedge clk_sys) disable iff (reset)
    pin_total == slot_map[`APMRB_SLOTS-1].base + {1'b0, slot_map[`APMRB_SLOTS-1].count})
    else $error("pin total does not follow the last slot");

  // Program event checks
  AST_START_EVT: assert property (@(posedge clk_sys) disable iff (reset)
    start_any[0] |=> start_event[0] && prog_running[0]) else $error("start event missing");
  AST_STOP_EVT: assert property (@(posedge clk_sys) disable iff (reset)
    stop_event[0] |-> $past(prog_running[0])) else $error("stop on idle program");
  AST_STOP_CLEARS: assert property (@(posedge clk_sys) disable iff (reset)
    stop_any[0] && !start_any[0] |=> !prog_running[0]) else $error("stopped program still running");

  COV_FACTORY: cover property (@(posedge clk_sys) reset_pulse.net_factory);
  COV_MODULE_RESET: cover property (@(posedge clk_sys) reset_pulse.all_modules && !reset_pulse.net_factory);
  COV_RENUMBER: cover property (@(posedge clk_sys) renumber_pulse);
  COV_STOP: cover property (@(posedge clk_sys) stop_event[0]);
  COV_BAND2: cover property (@(posedge clk_sys) led_ch2_red);
endmodule

// file: core/apmrb_params.svh
`ifndef APMRB_PARAMS_SVH
`define APMRB_PARAMS_SVH
`define APMRB_SLOTS 4
`define APMRB_PROGS 4
`define APMRB_TYPE_NONE 2'h0
`define APMRB_TYPE_ANALOG 2'h1
`define APMRB_TYPE_DIGITAL 2'h2
`define APMRB_PINS_ANALOG 7'h08
`define APMRB_PINS_DIGITAL 7'h20
`define APMRB_PINS_NONE 7'h00
`define APMRB_CLK_MHZ 100
`define APMRB_BAND1_S 3
`define APMRB_BAND2_S 10
`define APMRB_BAND1_CYC (`APMRB_BAND1_S * `APMRB_CLK_MHZ * 1000000)
`define APMRB_BAND2_CYC (`APMRB_BAND2_S * `APMRB_CLK_MHZ * 1000000)
`endif

// file: core/apmrb_pkg.sv
package apmrb_pkg;
  typedef logic [1:0] apmrb_type_t;
  typedef struct packed {
    logic [7:0] base;
    logic [6:0] count;
  } apmrb_slot_map_t;
  typedef struct packed {
    logic all_modules;
    logic net_factory;
  } apmrb_reset_t;
  typedef enum logic [2:0] {
    APMRB_IDLE = 3'b001,
    APMRB_BAND1 = 3'b010,
    APMRB_BAND2 = 3'b100
  } apmrb_btn_state_t;
endpackage

// file: core/apmrb_slot_numberer.sv
`timescale 1ns/100ps
`include "apmrb_params.svh"
module apmrb_slot_numberer
  import apmrb_pkg::*;
(
  // Types, leftmost slot at index 0
  input wire apmrb_type_t slot_type [`APMRB_SLOTS],
  // Computed map
  output apmrb_slot_map_t slot_map [`APMRB_SLOTS],
  output logic [7:0] pin_total
);
  logic [7:0] run_sum [`APMRB_SLOTS+1];
  assign run_sum[0] = 8'h00;
  genvar gi;
  generate
    for (gi = 0; gi < `APMRB_SLOTS; gi++) begin : g_slot
      wire [6:0] cnt = (slot_type[gi] == `APMRB_TYPE_ANALOG) ? `APMRB_PINS_ANALOG :
                       (slot_type[gi] == `APMRB_TYPE_DIGITAL) ? `APMRB_PINS_DIGITAL : `APMRB_PINS_NONE;
      // Empty slots add nothing, so the numbering has no gaps
      assign run_sum[gi+1] = run_sum[gi] + {1'b0, cnt};
      assign slot_map[gi].base = run_sum[gi]; // first output takes the base
      assign slot_map[gi].count = cnt;
    end
  endgenerate
  assign pin_total = run_sum[`APMRB_SLOTS];
endmodule

// file: test/apmrb_button_model.sv
`timescale 1ns/100ps
module apmrb_button_model (
  // Clock and request
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [7:0] hold_cyc,
  // Button line, high while pressed
  output logic btn_pin
);
  logic [7:0] left_ff = 8'h00;
  // Operator picks the reset type by the release moment
  always_ff @(posedge clk_sys) begin
    if (go) begin
      left_ff <= hold_cyc;
    end else if (left_ff != 8'h00) begin
      left_ff <= left_ff - 8'h01;
    end
  end
  assign btn_pin = (left_ff != 8'h00);
endmodule

// file: test/apmrb_testbench.sv
`timescale 1ns/100ps
`include "apmrb_params.svh"
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin error_cnt++; $display("mismatch %s exp %0h got %0h", n, e, s); end end
module testbench;
  import apmrb_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  apmrb_type_t ty [`APMRB_SLOTS] = '{default: 2'h0};
  logic go = 1'b0;
  logic [7:0] hold = 8'h00;
  logic btn_pin;
  logic [3:0] hs = 4'h0, hp = 4'h0, ps = 4'h0, pp = 4'h0;
  apmrb_slot_map_t map [`APMRB_SLOTS];
  logic [7:0] tot;
  logic ren, clr, l1, l2;
  apmrb_reset_t rp;
  logic [3:0] run, sev, pev;
  int error_cnt = 0;
  int cmp_count = 0;
  initial forever #5 clk_sys = ~clk_sys;
  apmrb_top #(.BAND1_CYC(20), .BAND2_CYC(100)) u_dut (.clk_sys(clk_sys), .reset(reset), .slot_type_pin(ty),
    .btn_pin(btn_pin), .host_program_start_call(hs), .host_program_stop_call(hp), .prog_start_req(ps),
    .prog_stop_req(pp), .slot_map(map), .pin_total(tot), .renumber_pulse(ren), .outputs_clear(clr),
    .led_ch1_red(l1), .led_ch2_red(l2), .reset_pulse(rp), .prog_running(run), .start_event(sev),
    .stop_event(pev));
  apmrb_button_model u_btn (.clk_sys(clk_sys), .go(go), .hold_cyc(hold), .btn_pin(btn_pin));
  task give_verdict;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Bounded wait on renumber pulse (0), module reset (1) or second LED (2)
  task automatic wait_hi(input int c);
    for (int i = 0; i < 200; i++) begin
      if ((c == 0 ? ren : c == 1 ? rp.all_modules : l2) === 1'b1) begin
        return;
      end
      @(posedge clk_sys);
      #1;
    end
    error_cnt++;
    give_verdict();
  endtask
  // Expected map is rebuilt from the slot types alone
  task automatic lineup(input apmrb_type_t a, b, c, d);
    logic [7:0] base;
    logic [6:0] cnt;
    base = 8'h00;
    @(posedge clk_sys);
    ty <= '{a, b, c, d};
    #1;
    wait_hi(0);
    `CHK("clear", 1'b1, clr)
    // The map is registered one cycle after the renumber pulse
    @(posedge clk_sys);
    #1;
    `CHK("pulse", 1'b0, ren)
    for (int i = 0; i < `APMRB_SLOTS; i++) begin
      cnt = ty[i] == `APMRB_TYPE_ANALOG ? `APMRB_PINS_ANALOG :
        ty[i] == `APMRB_TYPE_DIGITAL ? `APMRB_PINS_DIGITAL : 7'h00;
      `CHK("base", base, map[i].base)
      `CHK("count", cnt, map[i].count)
      base = base + {1'b0, cnt};
    end
    `CHK("total", base, tot)
  endtask
  task automatic button(input logic [7:0] h, input logic nf);
    @(posedge clk_sys);
    go <= 1'b1;
    hold <= h;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    `CHK("led1", 1'b1, l1)
    `CHK("led2 early", 1'b0, l2)
    if (nf) begin
      wait_hi(2);
      `CHK("led1 band2", 1'b1, l1)
    end
    wait_hi(1);
    `CHK("net reset", nf, rp.net_factory)
    @(posedge clk_sys);
    #1;
    `CHK("reset pulse", 1'b0, rp.all_modules)
  endtask
  task automatic prog(input logic [3:0] a, b, c, d, es, ep, er);
    @(posedge clk_sys);
    {hs, hp, ps, pp} <= {a, b, c, d};
    @(posedge clk_sys);
    {hs, hp, ps, pp} <= 16'h0000;
    #1;
    `CHK("start ev", es, sev)
    `CHK("stop ev", ep, pev)
    `CHK("running", er, run)
  endtask
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    lineup(2'h1, 2'h0, 2'h0, 2'h0);
    lineup(2'h1, 2'h2, 2'h0, 2'h0);
    lineup(2'h0, 2'h2, 2'h0, 2'h0);
    lineup(2'h2, 2'h1, 2'h0, 2'h0);
    lineup(2'h2, 2'h0, 2'h1, 2'h2);
    lineup(2'h2, 2'h2, 2'h2, 2'h2);
    button(8'h0A, 1'b0);
    button(8'h3C, 1'b1);
    prog(4'h0, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
    prog(4'h1, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h1);
    prog(4'h0, 4'h0, 4'h2, 4'h0, 4'h2, 4'h0, 4'h3);
    prog(4'h0, 4'h1, 4'h0, 4'h0, 4'h0, 4'h1, 4'h2);
    prog(4'h0, 4'h0, 4'h4, 4'h2, 4'h4, 4'h2, 4'h4);
    prog(4'h8, 4'h8, 4'h0, 4'h0, 4'h8, 4'h0, 4'hC);
    prog(4'h4, 4'h4, 4'h0, 4'h0, 4'h4, 4'h4, 4'hC);
    give_verdict();
  end
endmodule
